/* File: list_seq_pkg.sv */
package list_seq_pkg;

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE0 = 8'h04;
  localparam logic [7:0] REG_BASE1 = 8'h08;
  localparam logic [7:0] REG_BASE2 = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_PTR = 8'h14;
  localparam int CTRL_EN_BIT = 0;

  // list timing
  localparam logic [8:0] FIRST_LINE = 9'h008;

  // control byte bit positions
  localparam int C0_TEXT = 0;
  localparam int C0_GFX = 1;
  localparam int C0_OVL_OFF = 2;
  localparam int C0_ATTR_ON = 3;
  localparam int C0_ATTR_OFF = 4;
  localparam int C0_REPEAT = 5;
  localparam int C0_OVL_ADDR = 6;
  localparam int C0_OVL_SCROLL = 7;
  localparam int C1_FONT = 0;
  localparam int C1_ATTR_BASE = 1;
  localparam int C1_ATTR_LAYOUT = 2;
  localparam int C1_MISC = 3;
  localparam int C1_LORES = 4;
  localparam int C1_HIRES = 5;
  localparam int C1_END = 7;

  // optional block indices in fetch order and their byte counts
  localparam logic [2:0] BLK_REPEAT = 3'd0;
  localparam logic [2:0] BLK_OVL_ADDR = 3'd1;
  localparam logic [2:0] BLK_OVL_SCROLL = 3'd2;
  localparam logic [2:0] BLK_FONT = 3'd3;
  localparam logic [2:0] BLK_ATTR_BASE = 3'd4;
  localparam logic [2:0] BLK_ATTR_LAYOUT = 3'd5;
  localparam logic [2:0] BLK_MISC = 3'd6;
  localparam logic [2:0] LEN_REPEAT = 3'd1;
  localparam logic [2:0] LEN_OVL_ADDR = 3'd5;
  localparam logic [2:0] LEN_OVL_SCROLL = 3'd2;
  localparam logic [2:0] LEN_FONT = 3'd1;
  localparam logic [2:0] LEN_ATTR_BASE = 3'd5;
  localparam logic [2:0] LEN_ATTR_LAYOUT = 3'd4;
  localparam logic [2:0] LEN_MISC = 3'd2;

  // width codes, spans in color clocks and horizontal windows
  localparam logic [1:0] WIDTH_NARROW = 2'b00;
  localparam logic [1:0] WIDTH_NORMAL = 2'b01;
  localparam logic [1:0] WIDTH_WIDE = 2'b10;
  localparam logic [7:0] CLK_NARROW = 8'd128;
  localparam logic [7:0] CLK_NORMAL = 8'd160;
  localparam logic [7:0] CLK_WIDE = 8'd184;
  localparam logic [7:0] HPOS_NARROW_START = 8'h40;
  localparam logic [7:0] HPOS_NARROW_END = 8'hbf;
  localparam logic [7:0] HPOS_NORMAL_START = 8'h30;
  localparam logic [7:0] HPOS_NORMAL_END = 8'hcf;
  localparam logic [7:0] HPOS_WIDE_START = 8'h2c;
  localparam logic [7:0] HPOS_WIDE_END = 8'hd3;

  // per-frame defaults
  localparam logic [7:0] DEF_SCROLL = 8'h00;
  localparam logic [7:0] DEF_PRIORITY = 8'hff;
  localparam logic [7:0] DEF_CELL = 8'h07;
  localparam logic [1:0] DEF_PF_PAL = 2'd0;
  localparam logic [1:0] DEF_OV_PAL = 2'd1;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_WAIT = 7'b0000010,
    ST_CTL0 = 7'b0000100,
    ST_CTL1 = 7'b0001000,
    ST_OPT = 7'b0010000,
    ST_SHOW = 7'b0100000,
    ST_DONE = 7'b1000000
  } state_e;

  typedef enum logic [2:0] {
    MODE_OFF = 3'd0,
    MODE_STD = 3'd1,
    MODE_LORES = 3'd2,
    MODE_HIRES = 3'd3,
    MODE_TEXT = 3'd4
  } ov_mode_e;

  // display parameters handed to the renderer
  typedef struct packed {
    ov_mode_e mode;
    logic ov_on;
    logic attr_on;
    logic [18:0] row_addr;
    logic [11:0] ov_stride;
    logic [7:0] txt_hscroll;
    logic [7:0] txt_vscroll;
    logic [7:0] font_base;
    logic [18:0] attr_addr;
    logic [11:0] attr_stride;
    logic [7:0] attr_hscroll;
    logic [7:0] attr_vscroll;
    logic [7:0] cell_w;
    logic [7:0] cell_h;
    logic [1:0] width;
    logic [1:0] pf_pal;
    logic [1:0] ov_pal;
    logic [7:0] priority_mask;
    logic [7:0] hstart;
    logic [7:0] hend;
    logic [9:0] pixels;
  } ov_params_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage : list_seq_pkg

/* File: list_sequencer.sv */
`timescale 1ns/1ps

// Function
// - list fetching runs only while control enable bit 0 is set
// - each frame the list starts on scan line 8 at the base address
// - entry is two control bytes plus enabled optional blocks; parameters persist
// - control0 bit 5 loads repeat byte; line shown that many extra times
// - control0 bit 6 loads 19-bit overlay row address and 12-bit stride
// - control0 bit 7 loads text scroll values, used only in text mode
// - control1 bit 0 loads font base address bits 18..11
// - control1 bit 1 loads attribute map base and stride in multiples of four
// - control1 bit 2 loads attribute scroll and cell size, coded minus one
// - control1 bit 3 loads width, palettes and priority; width code decode
// - control1 bit 7 stops list processing for the rest of the frame
// - list pointer reloads from base registers at vertical sync start
// - frame start restores scroll, width, priority, attribute and palette defaults
// - overlay and attribute addresses are kept across frames
// - overlay widths narrow, normal, wide span 128, 160, 184 color clocks
// - mode decoded from text/graphics bits and low/high resolution bits
// - pixel counts at normal width 320 standard, 160 low, 640 high, 640 text
// - wide overlay spans horizontal positions 2c to d3
// - row address advances by stride every shown scan line, stride up to 4095
module list_sequencer
  import list_seq_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire list_seq_pkg::apb_req_s APB_REQ,
  output list_seq_pkg::apb_rsp_s APB_RSP,
  input wire logic VSYNC_START,
  input wire logic LINE_START,
  input wire logic [8:0] LINE_NUM,
  output logic MEM_REQ,
  output logic [18:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [7:0] MEM_DATA,
  output logic LINE_ACTIVE,
  output list_seq_pkg::ov_params_s OV_PARAMS
);
  import list_seq_pkg::*;

  typedef struct packed {
    state_e st;
    logic en;
    logic [18:0] base;
    logic [18:0] ptr;
    logic [7:0] cb0;
    logic [7:0] cb1;
    logic [6:0] pend;
    logic [2:0] bidx;
    logic [8:0] rep;
    ov_params_s p;
  } state_s;

  state_s s_q;
  state_s s_d;

  // lowest pending optional block
  function automatic logic [2:0] first_blk(input logic [6:0] m);
    logic [2:0] r;
    r = BLK_MISC;
    for (int i = 6; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : first_blk

  function automatic logic [2:0] blk_len(input logic [2:0] b);
    logic [2:0] r;
    case (b)
      BLK_REPEAT: r = LEN_REPEAT;
      BLK_OVL_ADDR: r = LEN_OVL_ADDR;
      BLK_OVL_SCROLL: r = LEN_OVL_SCROLL;
      BLK_FONT: r = LEN_FONT;
      BLK_ATTR_BASE: r = LEN_ATTR_BASE;
      BLK_ATTR_LAYOUT: r = LEN_ATTR_LAYOUT;
      default: r = LEN_MISC;
    endcase
    return r;
  endfunction : blk_len

  // geometry from width code and mode
  function automatic ov_params_s geometry(input ov_params_s p);
    ov_params_s r;
    logic [7:0] clks;
    r = p;
    case (p.width)
      WIDTH_NORMAL: begin
        clks = CLK_NORMAL;
        r.hstart = HPOS_NORMAL_START;
        r.hend = HPOS_NORMAL_END;
      end
      WIDTH_WIDE: begin
        clks = CLK_WIDE;
        r.hstart = HPOS_WIDE_START;
        r.hend = HPOS_WIDE_END;
      end
      default: begin
        clks = CLK_NARROW;
        r.hstart = HPOS_NARROW_START;
        r.hend = HPOS_NARROW_END;
      end
    endcase
    case (p.mode)
      MODE_STD: r.pixels = {1'b0, clks, 1'b0};
      MODE_LORES: r.pixels = {2'b00, clks};
      MODE_HIRES: r.pixels = {clks, 2'b00};
      MODE_TEXT: r.pixels = {clks, 2'b00};
      default: r.pixels = 10'h000;
    endcase
    return r;
  endfunction : geometry

  // frame defaults, leaving addresses untouched
  function automatic ov_params_s frame_defaults(input ov_params_s p);
    ov_params_s r;
    r = p;
    r.txt_hscroll = DEF_SCROLL;
    r.txt_vscroll = DEF_SCROLL;
    r.width = WIDTH_NORMAL;
    r.priority_mask = DEF_PRIORITY;
    r.attr_on = 1'b0;
    r.attr_hscroll = DEF_SCROLL;
    r.attr_vscroll = DEF_SCROLL;
    r.cell_w = DEF_CELL;
    r.cell_h = DEF_CELL;
    r.pf_pal = DEF_PF_PAL;
    r.ov_pal = DEF_OV_PAL;
    return r;
  endfunction : frame_defaults

  logic wr_en;
  logic fetching;
  logic [2:0] blk;

  // next-state logic for bus, list walk and parameters
  always_comb begin
    s_d = s_q;
    wr_en = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
    fetching = (s_q.st == ST_CTL0) || (s_q.st == ST_CTL1) || (s_q.st == ST_OPT);
    blk = first_blk(s_q.pend);
    APB_RSP.pready = 1'b1;
    APB_RSP.pslverr = 1'b0;
    APB_RSP.prdata = 32'h0000_0000;

    // register reads
    case (APB_REQ.paddr)
      REG_CTRL: APB_RSP.prdata = {31'h0000_0000, s_q.en};
      REG_BASE0: APB_RSP.prdata = {24'h00_0000, s_q.base[7:0]};
      REG_BASE1: APB_RSP.prdata = {24'h00_0000, s_q.base[15:8]};
      REG_BASE2: APB_RSP.prdata = {29'h0000_0000, s_q.base[18:16]};
      REG_STATUS: APB_RSP.prdata = {16'h0000, s_q.cb1, 1'b0, s_q.st};
      REG_PTR: APB_RSP.prdata = {13'h0000, s_q.ptr};
      default: APB_RSP.pslverr = APB_REQ.psel && APB_REQ.penable;
    endcase

    // register writes
    if (wr_en) begin
      case (APB_REQ.paddr)
        REG_CTRL: s_d.en = APB_REQ.pwdata[CTRL_EN_BIT];
        REG_BASE0: s_d.base[7:0] = APB_REQ.pwdata[7:0];
        REG_BASE1: s_d.base[15:8] = APB_REQ.pwdata[7:0];
        REG_BASE2: s_d.base[18:16] = APB_REQ.pwdata[2:0];
        default: ;
      endcase
    end

    // list walk
    case (s_q.st)
      ST_IDLE: ;
      ST_WAIT: begin
        if (LINE_START && LINE_NUM == FIRST_LINE) begin
          s_d.st = ST_CTL0;
        end
      end
      ST_CTL0: begin
        if (MEM_ACK) begin
          s_d.cb0 = MEM_DATA;
          s_d.ptr = s_q.ptr + 19'd1;
          s_d.st = ST_CTL1;
        end
      end
      ST_CTL1: begin
        if (MEM_ACK) begin
          s_d.cb1 = MEM_DATA;
          s_d.ptr = s_q.ptr + 19'd1;
          s_d.rep = 9'd0;
          s_d.bidx = 3'd0;
          s_d.pend = {MEM_DATA[C1_MISC], MEM_DATA[C1_ATTR_LAYOUT], MEM_DATA[C1_ATTR_BASE],
                      MEM_DATA[C1_FONT], s_q.cb0[C0_OVL_SCROLL], s_q.cb0[C0_OVL_ADDR],
                      s_q.cb0[C0_REPEAT]};
          if (s_q.cb0[C0_TEXT] && !s_q.cb0[C0_GFX]) begin
            s_d.p.mode = MODE_TEXT;
          end else if (!s_q.cb0[C0_TEXT] && s_q.cb0[C0_GFX]) begin
            if (MEM_DATA[C1_HIRES] && !MEM_DATA[C1_LORES]) begin
              s_d.p.mode = MODE_HIRES;
            end else if (MEM_DATA[C1_LORES] && !MEM_DATA[C1_HIRES]) begin
              s_d.p.mode = MODE_LORES;
            end else begin
              s_d.p.mode = MODE_STD;
            end
          end else begin
            s_d.p.mode = MODE_OFF;
          end
          s_d.p.ov_on = !s_q.cb0[C0_OVL_OFF];
          if (s_q.cb0[C0_ATTR_OFF]) begin
            s_d.p.attr_on = 1'b0;
          end else if (s_q.cb0[C0_ATTR_ON]) begin
            s_d.p.attr_on = 1'b1;
          end
          s_d.st = (s_d.pend == 7'h00) ? ST_SHOW : ST_OPT;
        end
      end
      ST_OPT: begin
        if (MEM_ACK) begin
          s_d.ptr = s_q.ptr + 19'd1;
          case (blk)
            BLK_REPEAT: s_d.rep = {1'b0, MEM_DATA};
            BLK_OVL_ADDR: begin
              case (s_q.bidx)
                3'd0: s_d.p.row_addr[7:0] = MEM_DATA;
                3'd1: s_d.p.row_addr[15:8] = MEM_DATA;
                3'd2: s_d.p.row_addr[18:16] = MEM_DATA[2:0];
                3'd3: s_d.p.ov_stride[7:0] = MEM_DATA;
                default: s_d.p.ov_stride[11:8] = MEM_DATA[3:0];
              endcase
            end
            BLK_OVL_SCROLL: begin
              if (s_q.bidx == 3'd0) begin
                s_d.p.txt_hscroll = MEM_DATA;
              end else begin
                s_d.p.txt_vscroll = MEM_DATA;
              end
            end
            BLK_FONT: s_d.p.font_base = MEM_DATA;
            BLK_ATTR_BASE: begin
              case (s_q.bidx)
                3'd0: s_d.p.attr_addr[7:0] = MEM_DATA;
                3'd1: s_d.p.attr_addr[15:8] = MEM_DATA;
                3'd2: s_d.p.attr_addr[18:16] = MEM_DATA[2:0];
                3'd3: s_d.p.attr_stride[7:0] = {MEM_DATA[7:2], 2'b00};
                default: s_d.p.attr_stride[11:8] = MEM_DATA[3:0];
              endcase
            end
            BLK_ATTR_LAYOUT: begin
              case (s_q.bidx)
                3'd0: s_d.p.attr_hscroll = MEM_DATA;
                3'd1: s_d.p.attr_vscroll = MEM_DATA;
                3'd2: s_d.p.cell_w = MEM_DATA;
                default: s_d.p.cell_h = MEM_DATA;
              endcase
            end
            default: begin
              if (s_q.bidx == 3'd0) begin
                s_d.p.pf_pal = MEM_DATA[7:6];
                s_d.p.ov_pal = MEM_DATA[5:4];
                s_d.p.width = MEM_DATA[1:0];
              end else begin
                s_d.p.priority_mask = MEM_DATA;
              end
            end
          endcase
          if (s_q.bidx == blk_len(blk) - 3'd1) begin
            s_d.pend[blk] = 1'b0;
            s_d.bidx = 3'd0;
            if (s_d.pend == 7'h00) begin
              s_d.st = ST_SHOW;
            end
          end else begin
            s_d.bidx = s_q.bidx + 3'd1;
          end
        end
      end
      ST_SHOW: begin
        if (LINE_START) begin
          s_d.p.row_addr = s_q.p.row_addr + {7'h00, s_q.p.ov_stride};
          if (s_q.rep == 9'd0) begin
            s_d.st = s_q.cb1[C1_END] ? ST_DONE : ST_CTL0;
          end else begin
            s_d.rep = s_q.rep - 9'd1;
          end
        end
      end
      ST_DONE: ;
      default: s_d.st = ST_IDLE;
    endcase

    // frame restart at vertical sync
    if (VSYNC_START) begin
      s_d.ptr = s_q.base;
      s_d.p = frame_defaults(s_d.p);
      s_d.st = ST_WAIT;
    end
    if (!s_d.en) begin
      s_d.st = ST_IDLE;
    end
    s_d.p = geometry(s_d.p);

    MEM_REQ = fetching && s_q.en;
    MEM_ADDR = s_q.ptr;
    LINE_ACTIVE = (s_q.st == ST_SHOW);
    OV_PARAMS = s_q.p;
  end

  // state register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.p <= geometry(frame_defaults('0));
    end else begin
      s_q <= s_d;
    end
  end

endmodule : list_sequencer

/* File: list_seq_sva.sv */
`timescale 1ns/1ps
module list_seq_sva
  import list_seq_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire list_seq_pkg::apb_req_s APB_REQ,
  input wire list_seq_pkg::apb_rsp_s APB_RSP,
  input wire logic VSYNC_START,
  input wire logic LINE_START,
  input wire logic [8:0] LINE_NUM,
  input wire logic MEM_REQ,
  input wire logic [18:0] MEM_ADDR,
  input wire logic MEM_ACK,
  input wire logic [7:0] MEM_DATA,
  input wire logic LINE_ACTIVE,
  input wire list_seq_pkg::ov_params_s OV_PARAMS
);
  logic en_q;
  logic armed_q;
  logic [18:0] base_q;
  logic [18:0] start_q;
  logic wr;
  assign wr = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  // shadow of enable and base, frame start address latched at vsync
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      en_q <= 1'b0;
      armed_q <= 1'b0;
      base_q <= 19'h00000;
      start_q <= 19'h00000;
    end else begin
      if (wr && APB_REQ.paddr == REG_CTRL) en_q <= APB_REQ.pwdata[CTRL_EN_BIT];
      if (wr && APB_REQ.paddr == REG_BASE0) base_q[7:0] <= APB_REQ.pwdata[7:0];
      if (wr && APB_REQ.paddr == REG_BASE1) base_q[15:8] <= APB_REQ.pwdata[7:0];
      if (wr && APB_REQ.paddr == REG_BASE2) base_q[18:16] <= APB_REQ.pwdata[2:0];
      if (VSYNC_START && en_q) begin
        armed_q <= 1'b1;
        start_q <= base_q;
      end else if (LINE_START && LINE_NUM == FIRST_LINE) begin
        armed_q <= 1'b0;
      end
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  fetch_when_off_a: assert property (!en_q |=> !MEM_REQ)
    else $error("list fetch while disabled");
  list_start_a: assert property (LINE_START && LINE_NUM == FIRST_LINE && armed_q && en_q
    |-> ##[1:2] (MEM_REQ && MEM_ADDR == start_q)) else $error("list start wrong");
  vsync_stop_a: assert property (VSYNC_START |=> !MEM_REQ)
    else $error("fetch kept over vsync");
  byte_step_a: assert property (MEM_REQ && MEM_ACK && en_q && !VSYNC_START
    |=> MEM_ADDR == $past(MEM_ADDR) + 19'h00001) else $error("list pointer step wrong");
  frame_defaults_a: assert property (VSYNC_START && en_q |=> OV_PARAMS.width == WIDTH_NORMAL
    && OV_PARAMS.priority_mask == DEF_PRIORITY && !OV_PARAMS.attr_on
    && OV_PARAMS.txt_hscroll == DEF_SCROLL && OV_PARAMS.attr_vscroll == DEF_SCROLL
    && OV_PARAMS.cell_w == DEF_CELL && OV_PARAMS.cell_h == DEF_CELL
    && OV_PARAMS.pf_pal == DEF_PF_PAL && OV_PARAMS.ov_pal == DEF_OV_PAL)
    else $error("frame defaults missing");
  wide_span_a: assert property (OV_PARAMS.width == WIDTH_WIDE |->
    OV_PARAMS.hstart == HPOS_WIDE_START && OV_PARAMS.hend == HPOS_WIDE_END)
    else $error("wide window wrong");
  std_pixels_a: assert property (OV_PARAMS.mode == MODE_STD && OV_PARAMS.width == WIDTH_NORMAL
    |-> OV_PARAMS.pixels == {1'b0, CLK_NORMAL, 1'b0}) else $error("pixel count wrong");
  row_stride_a: assert property (LINE_START && LINE_ACTIVE && en_q && !VSYNC_START |=>
    OV_PARAMS.row_addr == $past(OV_PARAMS.row_addr) + {7'h00, OV_PARAMS.ov_stride})
    else $error("row advance wrong");
  apb_answer_a: assert property (APB_REQ.psel && APB_REQ.penable |-> APB_RSP.pready
    && APB_RSP.pslverr == (APB_REQ.paddr > REG_PTR || APB_REQ.paddr[1:0] != 2'b00))
    else $error("apb answer wrong");
endmodule : list_seq_sva

bind list_sequencer list_seq_sva u_list_seq_sva (.SYS_CLK(SYS_CLK), .RST(RST),
  .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .VSYNC_START(VSYNC_START), .LINE_START(LINE_START),
  .LINE_NUM(LINE_NUM), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK),
  .MEM_DATA(MEM_DATA), .LINE_ACTIVE(LINE_ACTIVE), .OV_PARAMS(OV_PARAMS));

/* File: list_mem_model.sv */
`timescale 1ns/1ps
module list_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic req,
  input wire logic [18:0] addr,
  output logic ack,
  output logic [7:0] data
);
  logic [7:0] mem [0:255];
  logic [1:0] wait_q;
  // one byte per request, two idle cycles first when slow; data churns when idle
  always_ff @(posedge clk) begin
    data <= ~data;
    if (rst || !req || ack) begin
      ack <= 1'b0;
      wait_q <= {slow, 1'b0};
    end else if (wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else begin
      ack <= 1'b1;
      data <= mem[addr[7:0]];
    end
    if (rst) data <= 8'h5a;
  end
endmodule : list_mem_model

/* File: list_sequencer_test.sv */
`timescale 1ns/1ps
module list_sequencer_test;
  import list_seq_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  apb_req_s apb_req = '0;
  apb_rsp_s apb_rsp;
  logic vsync = 1'b0;
  logic line_start = 1'b0;
  logic [8:0] line_num = 9'h000;
  logic slow = 1'b0;
  logic mem_req;
  logic mem_ack;
  logic line_active;
  logic err;
  logic [18:0] mem_addr;
  logic [7:0] mem_data;
  logic [31:0] rd;
  ov_params_s ov;
  ov_params_s e;
  int mismatches = 0;
  int samples_checked = 0;
  int req_seen = 0;
  // entry0 sets addresses first, then entry1 with end bit
  localparam logic [7:0] LIST [0:23] = '{8'hea, 8'h2f, 8'h02, 8'h45, 8'h23, 8'h01, 8'hff,
    8'h07, 8'h03, 8'h04, 8'h5a, 8'h00, 8'h10, 8'h02, 8'h47, 8'h03, 8'h01, 8'h02, 8'h0f,
    8'h1f, 8'he2, 8'h0f, 8'h15, 8'h80};
  list_sequencer u_list_sequencer (.SYS_CLK(SYS_CLK), .RST(RST), .APB_REQ(apb_req),
    .APB_RSP(apb_rsp), .VSYNC_START(vsync), .LINE_START(line_start), .LINE_NUM(line_num),
    .MEM_REQ(mem_req), .MEM_ADDR(mem_addr), .MEM_ACK(mem_ack), .MEM_DATA(mem_data),
    .LINE_ACTIVE(line_active), .OV_PARAMS(ov));
  list_mem_model u_list_mem_model (.clk(SYS_CLK), .rst(RST), .slow(slow), .req(mem_req),
    .addr(mem_addr), .ack(mem_ack), .data(mem_data));
  always #2.5 SYS_CLK = ~SYS_CLK;
  // count cycles with a list fetch pending
  always @(posedge SYS_CLK) begin
    if (mem_req === 1'b1) req_seen++;
  end
  task automatic check(input string what, input logic [191:0] seen, input logic [191:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer; answer taken at the rising edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge SYS_CLK);
    apb_req.penable <= 1'b1;
    @(posedge SYS_CLK);
    while (apb_rsp.pready !== 1'b1 && n < 20) begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n == 20) mismatches++;
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge SYS_CLK);
  endtask : apb
  // vsync or line start pulse, then one line time
  task automatic strobe(input logic v, input logic [8:0] n);
    vsync <= v;
    line_start <= !v;
    line_num <= n;
    @(posedge SYS_CLK);
    vsync <= 1'b0;
    line_start <= 1'b0;
    repeat (200) @(posedge SYS_CLK);
  endtask : strobe
  task automatic t_regs;
    apb(1'b0, REG_CTRL, 32'h0);
    check("ctrl", rd, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    check("status", rd[6:0], ST_IDLE);
    apb(1'b1, REG_BASE0, 32'h10);
    apb(1'b0, REG_BASE0, 32'h0);
    check("base0", rd[7:0], 8'h10);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    apb(1'b1, REG_CTRL, 32'h1);
  endtask : t_regs
  task automatic t_frame1;
    slow <= 1'b1;
    strobe(1'b1, 9'h000);
    strobe(1'b0, 9'h007);
    apb(1'b0, REG_PTR, 32'h0);
    check("early ptr", rd, 32'h10);
    strobe(1'b0, FIRST_LINE);
    e = '{mode: MODE_HIRES, ov_on: 1'b1, attr_on: 1'b1, row_addr: 19'h12345,
      ov_stride: 12'h7ff, txt_hscroll: 8'h03, txt_vscroll: 8'h04, font_base: 8'h5a,
      attr_addr: 19'h21000, attr_stride: 12'h344, attr_hscroll: 8'h01, attr_vscroll: 8'h02,
      cell_w: 8'h0f, cell_h: 8'h1f, width: WIDTH_WIDE, pf_pal: 2'h3, ov_pal: 2'h2,
      priority_mask: 8'h0f, hstart: HPOS_WIDE_START, hend: HPOS_WIDE_END,
      pixels: {CLK_WIDE, 2'b00}};
    check("entry0", ov, e);
    check("line active", line_active, 1'b1);
    for (int i = 9; i < 12; i++) strobe(1'b0, 9'(i));
    e.mode = MODE_TEXT;
    e.ov_on = 1'b0;
    e.attr_on = 1'b0;
    e.row_addr = 19'h13b42;
    check("entry1", ov, e);
    strobe(1'b0, 9'h00c);
    strobe(1'b0, 9'h00d);
    apb(1'b0, REG_STATUS, 32'h0);
    check("done", rd[15:0], {8'h80, 1'b0, ST_DONE});
    check("line idle", line_active, 1'b0);
    apb(1'b0, REG_PTR, 32'h0);
    check("ptr", rd, 32'h28);
  endtask : t_frame1
  task automatic t_frame2;
    slow <= 1'b0;
    u_list_mem_model.mem[8'h40] = 8'h12;
    u_list_mem_model.mem[8'h41] = 8'h80;
    apb(1'b1, REG_BASE0, 32'h40);
    strobe(1'b1, 9'h000);
    strobe(1'b0, FIRST_LINE);
    e = '{mode: MODE_STD, ov_on: 1'b1, attr_on: 1'b0, row_addr: 19'h14341,
      ov_stride: 12'h7ff, txt_hscroll: DEF_SCROLL, txt_vscroll: DEF_SCROLL, font_base: 8'h5a,
      attr_addr: 19'h21000, attr_stride: 12'h344, attr_hscroll: DEF_SCROLL,
      attr_vscroll: DEF_SCROLL, cell_w: DEF_CELL, cell_h: DEF_CELL, width: WIDTH_NORMAL,
      pf_pal: DEF_PF_PAL, ov_pal: DEF_OV_PAL, priority_mask: DEF_PRIORITY,
      hstart: HPOS_NORMAL_START, hend: HPOS_NORMAL_END, pixels: {1'b0, CLK_NORMAL, 1'b0}};
    check("entry2", ov, e);
    apb(1'b0, REG_PTR, 32'h0);
    check("ptr2", rd, 32'h42);
  endtask : t_frame2
  task automatic t_off;
    int seen;
    apb(1'b1, REG_CTRL, 32'h0);
    seen = req_seen;
    strobe(1'b1, 9'h000);
    strobe(1'b0, FIRST_LINE);
    check("fetch while off", 32'(req_seen - seen), 32'h0);
  endtask : t_off
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    for (int i = 0; i < 24; i++) u_list_mem_model.mem[8'h10 + i] = LIST[i];
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_regs();
    t_frame1();
    t_frame2();
    t_off();
    final_report();
  end
  // watchdog
  initial begin
    #100us;
    mismatches++;
    final_report();
  end
endmodule : list_sequencer_test
